// ===== rtl/pp_host_pkg.sv
package pp_host_pkg;

   // Port modes selected by the user side
   typedef enum logic [2:0]
   {
      MODE_STANDARD  = 3'h0,
      MODE_NIBBLE    = 3'h1,
      MODE_BYTE      = 3'h2,
      MODE_ENHANCED  = 3'h3,
      MODE_EXTENDED  = 3'h4,
      MODE_FIFO      = 3'h5
   } port_mode_t;

   localparam int DATA_W        = 8;
   localparam int CLK_PERIOD_NS = 100;
   // Least strobe setup, pulse and init pulse times
   localparam int SETUP_NS      = 500;
   localparam int STROBE_NS     = 500;
   localparam int INIT_NS       = 50000;
   localparam int SETUP_CYC     = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STROBE_CYC    = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int INIT_CYC      = (INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W         = 10;
   localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
   localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;

endpackage

// ===== rtl/pp_status_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for a bundle of levels
module pp_status_sync
   import pp_host_pkg::*;
#(
   parameter int WIDTH = 5
)
(
   input  wire logic             clk_sys,
   input  wire logic             sys_rst,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] sync_d;

   // A bundle with no lines cannot be served
   if (WIDTH < 1)
   begin : g_width_check
      $error("synchroniser width must be at least one");
   end

   // Reset to all-ones: idle pulled-up lines read high
   always_comb
   begin
      meta_d = async_in;
      sync_d = meta_q;
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         meta_q <= '1;
         sync_q <= '1;
      end
      else
      begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign sync_out = sync_q;

endmodule

// ===== rtl/pp_host_port.sv
`timescale 1ns/1ps
module pp_host_port
   import pp_host_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              sys_rst,
   // User side
   input  wire port_mode_t        mode_sel,
   input  wire logic              negotiate,
   input  wire logic              reverse_req,
   input  wire logic              auto_feed_req,
   input  wire logic              select_req,
   input  wire logic              init_req,
   input  wire logic              tx_valid,
   input  wire logic [DATA_W-1:0] tx_data,
   output logic                   tx_ready,
   output logic                   tx_done,
   output logic [DATA_W-1:0]      rx_data,
   output logic                   periph_busy,
   output logic                   periph_paper_out,
   output logic                   periph_online,
   output logic                   periph_error,
   // Link side
   output logic                   strobe_low,
   output logic                   auto_line_feed_low,
   output logic                   init_low,
   output logic                   peripheral_select_low,
   output logic                   peripheral_select_oe_low,
   output logic                   transfer_direction,
   output logic [DATA_W-1:0]      data_out,
   output logic                   data_oe_low,
   input  wire logic [DATA_W-1:0] data_in,
   input  wire logic              ack_low,
   input  wire logic              busy,
   input  wire logic              paper_out_flag,
   input  wire logic              online,
   input  wire logic              fault_low
);

   typedef enum logic [2:0] {S_IDLE, S_SETUP, S_STROBE, S_WAIT_ACK, S_INIT} st_t;

   logic [4:0]        stat_s;
   logic              ack_s;
   logic              busy_s;
   logic              paper_s;
   logic              online_s;
   logic              fault_low_s;
   logic              ack_prev_q;
   logic              ack_prev_d;
   logic              ack_rise;
   st_t               st_q;
   st_t               st_d;
   logic [CNT_W-1:0]  cnt_q;
   logic [CNT_W-1:0]  cnt_d;
   logic [DATA_W-1:0] dout_q;
   logic [DATA_W-1:0] dout_d;
   logic              strobe_q;
   logic              strobe_d;
   logic              init_q;
   logic              init_d;
   logic              done_q;
   logic              done_d;
   logic              ready_q;
   logic              ready_d;
   logic              afd_q;
   logic              afd_d;
   logic              sel_q;
   logic              sel_d;
   logic              dir_q;
   logic              dir_d;
   logic              doe_q;
   logic              doe_d;
   logic [DATA_W-1:0] rx_q;
   logic [DATA_W-1:0] rx_d;
   logic [3:0]        st_flags_q;
   logic [3:0]        st_flags_d;

   // Modes where the host may turn the data bus round
   function automatic logic mode_bidir(input port_mode_t m);
      return (m != MODE_STANDARD) && (m != MODE_NIBBLE) && (m != MODE_FIFO);
   endfunction

   // Status lines cross in from the cable before any use
   pp_status_sync #(.WIDTH(5)) u_sync
   (
      .clk_sys  (clk_sys),
      .sys_rst  (sys_rst),
      .async_in ({ack_low, busy, paper_out_flag, online, fault_low}),
      .sync_out (stat_s)
   );

   assign {ack_s, busy_s, paper_s, online_s, fault_low_s} = stat_s;
   assign ack_rise = ack_s && !ack_prev_q; // End of the acknowledge pulse

   // Handshake sequencer and pin levels
   always_comb
   begin
      st_d       = st_q;
      cnt_d      = cnt_q;
      dout_d     = dout_q;
      strobe_d   = 1'b1;
      init_d     = 1'b1;
      done_d     = 1'b0;
      ack_prev_d = ack_s;
      afd_d      = !auto_feed_req;
      sel_d      = !select_req;
      rx_d       = rx_q;
      // Reverse only in bidirectional modes, never during negotiation
      dir_d      = !(reverse_req && mode_bidir(mode_sel) && !negotiate);
      // Nibble mode floats the bus unless negotiating
      doe_d      = !(dir_d && (mode_sel != MODE_NIBBLE || negotiate));
      if (!dir_q)
      begin
         rx_d = data_in;
      end
      case (st_q)
         S_IDLE:
         begin
            if (init_req)
            begin
               st_d   = S_INIT;
               cnt_d  = CNT_W'(INIT_CYC - 1);
               init_d = 1'b0;
            end
            else if (tx_valid && !busy_s && !doe_q && !negotiate)
            begin
               dout_d = tx_data;
               st_d   = S_SETUP;
               cnt_d  = CNT_W'(SETUP_CYC - 1);
            end
         end
         S_SETUP:
         begin
            if (cnt_q == CNT_ZERO)
            begin
               st_d     = S_STROBE;
               cnt_d    = CNT_W'(STROBE_CYC - 1);
               strobe_d = 1'b0;
            end
            else
            begin
               cnt_d = cnt_q - 1'b1;
            end
         end
         S_STROBE:
         begin
            if (cnt_q == CNT_ZERO)
            begin
               st_d = S_WAIT_ACK;
            end
            else
            begin
               cnt_d    = cnt_q - 1'b1;
               strobe_d = 1'b0;             // Data held by dout_q throughout
            end
         end
         S_WAIT_ACK:
         begin
            if (ack_rise)
            begin
               st_d   = S_IDLE;
               done_d = 1'b1;
            end
         end
         S_INIT:
         begin
            if (cnt_q == CNT_ZERO)
            begin
               st_d = S_IDLE;               // Back to compatibility idle
            end
            else
            begin
               cnt_d  = cnt_q - 1'b1;
               init_d = 1'b0;
            end
         end
         default:
         begin
            st_d = S_IDLE;
         end
      endcase
      // Only from a quiet idle link whose bus the host drives; never strobe a floated bus
      ready_d    = (st_d == S_IDLE) && !busy_s && !doe_d && !negotiate && !init_req;
      // Raw levels; paper-out implies fault is the peripheral's duty
      st_flags_d = {busy_s, paper_s, online_s, !fault_low_s};
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         st_q       <= S_IDLE;
         cnt_q      <= CNT_ZERO;
         dout_q     <= DATA_ZERO;
         strobe_q   <= 1'b1;                // Inactive high after reset
         init_q     <= 1'b1;
         done_q     <= 1'b0;
         ready_q    <= 1'b0;
         afd_q      <= 1'b1;
         sel_q      <= 1'b1;
         dir_q      <= 1'b1;
         doe_q      <= 1'b0;
         rx_q       <= DATA_ZERO;
         ack_prev_q <= 1'b1;
         st_flags_q <= 4'h2;
      end
      else
      begin
         st_q       <= st_d;
         cnt_q      <= cnt_d;
         dout_q     <= dout_d;
         strobe_q   <= strobe_d;
         init_q     <= init_d;
         done_q     <= done_d;
         ready_q    <= ready_d;
         afd_q      <= afd_d;
         sel_q      <= sel_d;
         dir_q      <= dir_d;
         doe_q      <= doe_d;
         rx_q       <= rx_d;
         ack_prev_q <= ack_prev_d;
         st_flags_q <= st_flags_d;
      end
   end

   assign strobe_low               = strobe_q;
   assign init_low                 = init_q;
   assign auto_line_feed_low       = afd_q;
   assign peripheral_select_low    = sel_q;
   assign peripheral_select_oe_low = 1'b0; // Always driven by the host, never released
   assign transfer_direction       = dir_q;
   assign data_out                 = dout_q;
   assign data_oe_low              = doe_q;
   assign tx_ready                 = ready_q;
   assign tx_done                  = done_q;
   assign rx_data                  = rx_q;
   assign {periph_busy, periph_paper_out, periph_online, periph_error} = st_flags_q;

   // Strobe low lasts exactly the pulse width
   property p_strobe_width;
      @(posedge clk_sys) disable iff (sys_rst)
      $fell(strobe_low) |-> !strobe_low [*5] ##1 strobe_low;
   endproperty
   a_strobe_width: assert property (p_strobe_width) else $error("strobe width wrong");
   // Data stable while strobe is low
   property p_data_stable;
      @(posedge clk_sys) disable iff (sys_rst)
      !strobe_low && $past(!strobe_low) |-> $stable(data_out) && !data_oe_low;
   endproperty
   a_data_stable: assert property (p_data_stable) else $error("data moved under strobe");
   property p_auto_feed;
      @(posedge clk_sys) disable iff (sys_rst)
      auto_feed_req |=> !auto_line_feed_low;
   endproperty
   a_auto_feed: assert property (p_auto_feed) else $error("auto feed not low");
   property p_init;
      @(posedge clk_sys) disable iff (sys_rst)
      $fell(init_low) |-> strobe_low throughout (##[1:600] init_low);
   endproperty
   a_init: assert property (p_init) else $error("init pulse bad");
   property p_select;
      @(posedge clk_sys) disable iff (sys_rst)
      select_req |=> !peripheral_select_low && !peripheral_select_oe_low;
   endproperty
   a_select: assert property (p_select) else $error("select not driven");
   property p_done;
      @(posedge clk_sys) disable iff (sys_rst)
      tx_done |-> strobe_low && $past(st_q) == S_WAIT_ACK;
   endproperty
   a_done: assert property (p_done) else $error("done without ack");
   property p_dir;
      @(posedge clk_sys) disable iff (sys_rst)
      !transfer_direction |-> data_oe_low;
   endproperty
   a_dir: assert property (p_dir) else $error("drove bus in reverse");
   property p_nibble;
      @(posedge clk_sys) disable iff (sys_rst)
      $past(mode_sel == MODE_NIBBLE && !negotiate) |-> data_oe_low;
   endproperty
   a_nibble: assert property (p_nibble) else $error("bus driven in nibble");

endmodule

// ===== tb/pp_printer_model.sv
`timescale 1ns/1ps
// Behavioural printer: latches each strobed byte, then acks it
module pp_printer_model
(
   input  wire logic       clk_sys,
   input  wire logic       strobe_low,
   input  wire logic [7:0] data_out,
   input  wire logic       data_oe_low,
   input  wire logic       transfer_direction,
   input  wire logic       hold_busy,
   input  wire logic [3:0] ack_wait,
   input  wire logic [7:0] rev_byte,
   input  wire logic       paper_jam,
   input  wire logic       go_offline,
   output logic            ack_low,
   output logic            busy,
   output logic [7:0]      data_in,
   output logic [7:0]      got_byte,
   output logic            paper_out_flag,
   output logic            online,
   output logic            fault_low
);
   logic busy_q;

   // One byte per strobe; busy covers the whole handshake
   initial
   begin
      ack_low = 1'b1;
      busy_q = 1'b0;
      got_byte = 8'h00;
      forever
      begin
         @(negedge strobe_low);
         #10 busy_q = 1'b1;
         @(posedge strobe_low);
         got_byte = data_out;
         repeat (ack_wait) @(posedge clk_sys);
         #10 ack_low = 1'b0;
         repeat (3) @(posedge clk_sys);
         #10 ack_low = 1'b1;
         busy_q = 1'b0;
      end
   end

   // Bus level from both drivers; pull-ups win when nobody drives
   assign busy = busy_q | hold_busy;
   assign data_in = !data_oe_low ? data_out : (!transfer_direction ? rev_byte : 8'hFF);
   assign paper_out_flag = paper_jam;
   assign fault_low = !paper_jam;
   assign online = !go_offline;
endmodule

// ===== tb/test_pp_host_port.sv
`timescale 1ns/1ps
module test_pp_host_port;
   import pp_host_pkg::*;
   logic              clk_sys, sys_rst, negotiate, reverse_req, auto_feed_req;
   logic              select_req, init_req, tx_valid, tx_ready, tx_done;
   logic              hold_busy, paper_jam, go_offline;
   port_mode_t        mode_sel;
   logic [7:0]        tx_data, rx_data, data_out, data_in, got_byte;
   logic [3:0]        ack_wait;
   logic              periph_busy, periph_paper_out, periph_online, periph_error;
   logic              strobe_low, auto_line_feed_low, init_low, peripheral_select_low;
   logic              peripheral_select_oe_low, transfer_direction, data_oe_low;
   logic              ack_low, busy, paper_out_flag, online, fault_low;
   int                n_mismatch = 0;
   int                total_checks = 0;

   pp_host_port u_pp_host_port (.clk_sys(clk_sys), .sys_rst(sys_rst), .mode_sel(mode_sel),
      .negotiate(negotiate), .reverse_req(reverse_req), .auto_feed_req(auto_feed_req),
      .select_req(select_req), .init_req(init_req), .tx_valid(tx_valid), .tx_data(tx_data),
      .tx_ready(tx_ready), .tx_done(tx_done), .rx_data(rx_data), .periph_busy(periph_busy),
      .periph_paper_out(periph_paper_out), .periph_online(periph_online),
      .periph_error(periph_error), .strobe_low(strobe_low),
      .auto_line_feed_low(auto_line_feed_low), .init_low(init_low),
      .peripheral_select_low(peripheral_select_low),
      .peripheral_select_oe_low(peripheral_select_oe_low),
      .transfer_direction(transfer_direction), .data_out(data_out),
      .data_oe_low(data_oe_low), .data_in(data_in), .ack_low(ack_low), .busy(busy),
      .paper_out_flag(paper_out_flag), .online(online), .fault_low(fault_low));

   pp_printer_model u_pp_printer_model (.clk_sys(clk_sys), .strobe_low(strobe_low),
      .data_out(data_out), .data_oe_low(data_oe_low),
      .transfer_direction(transfer_direction), .hold_busy(hold_busy), .ack_wait(ack_wait),
      .rev_byte(8'h3C), .paper_jam(paper_jam), .go_offline(go_offline), .ack_low(ack_low),
      .busy(busy), .data_in(data_in), .got_byte(got_byte),
      .paper_out_flag(paper_out_flag), .online(online), .fault_low(fault_low));

   // Free-running 10 MHz clock
   initial
   begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   // Inputs always move 10 ns after the edge, clear of sampling
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
      #10;
   endtask

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Bounded waits so a stuck handshake shows up as a mismatch
   task automatic send_byte(input logic [7:0] b);
      int n;
      n = 0;
      while (tx_ready !== 1'b1 && n < 200) begin step(1); n++; end
      tx_data = b;
      tx_valid = 1'b1;
      step(1);
      tx_valid = 1'b0;
      n = 0;
      while (strobe_low !== 1'b0 && n < 20) begin step(1); n++; end
      n = 0;
      while (strobe_low === 1'b0 && n < 20) begin check(data_out, b); step(1); n++; end
      check(n, STROBE_CYC);
      n = 0;
      while (tx_done !== 1'b1 && n < 100) begin step(1); n++; end
      check(tx_done, 1'b1);
      check(got_byte, b);
   endtask

   task automatic test_reset();
      check({strobe_low, auto_line_feed_low, init_low, peripheral_select_low}, 4'hF);
      check({transfer_direction, data_oe_low}, 2'h2);
      $display("reset levels done");
   endtask

   task automatic test_bytes();
      send_byte(8'hA5);
      ack_wait = 4'hC;
      send_byte(8'h5A);
      ack_wait = 4'h2;
      $display("byte transfers done");
   endtask

   task automatic test_busy();
      // Busy must cross the synchroniser before the byte is offered
      hold_busy = 1'b1;
      step(3);
      tx_valid = 1'b1;
      step(6);
      check({periph_busy, tx_ready, strobe_low}, 3'h5);
      tx_valid = 1'b0;
      hold_busy = 1'b0;
      step(6);
      check({periph_busy, tx_ready}, 2'h1);
      $display("busy refusal done");
   endtask

   task automatic test_controls();
      auto_feed_req = 1'b1;
      select_req = 1'b1;
      step(1);
      check({auto_line_feed_low, peripheral_select_low}, 2'h0);
      check(peripheral_select_oe_low, 1'b0);
      auto_feed_req = 1'b0;
      select_req = 1'b0;
      step(1);
      check({auto_line_feed_low, peripheral_select_low}, 2'h3);
      $display("control lines done");
   endtask

   task automatic test_init();
      int n;
      init_req = 1'b1;
      step(1);
      init_req = 1'b0;
      n = 0;
      while (init_low !== 1'b0 && n < 5) begin step(1); n++; end
      n = 0;
      while (init_low === 1'b0 && n < 1000) begin step(1); n++; end
      check(n, INIT_CYC);
      check({strobe_low, transfer_direction}, 2'h3);
      $display("init pulse done");
   endtask

   task automatic test_modes();
      logic rev;
      reverse_req = 1'b1;
      for (int m = 0; m < 6; m++)
      begin
         mode_sel = port_mode_t'(m);
         rev = (m == 2 || m == 3 || m == 4);
         step(4);
         check(transfer_direction, !rev);
         check(data_oe_low, rev || m == 1);
         if (rev)
            check(rx_data, 8'h3C);
      end
      reverse_req = 1'b0;
      // Negotiation drives the bus even in nibble mode
      mode_sel = MODE_NIBBLE;
      negotiate = 1'b1;
      step(3);
      check({data_oe_low, tx_ready}, 2'h0);
      negotiate = 1'b0;
      step(2);
      $display("modes done");
   endtask

   task automatic test_status();
      paper_jam = 1'b1;
      step(5);
      check({periph_paper_out, periph_error, periph_online}, 3'h7);
      paper_jam = 1'b0;
      go_offline = 1'b1;
      step(5);
      check({periph_paper_out, periph_error, periph_online}, 3'h0);
      go_offline = 1'b0;
      $display("status lines done");
   endtask

   // Watchdog well beyond the expected run of about 620 cycles
   initial
   begin
      #(3000 * CLK_PERIOD_NS);
      n_mismatch++;
      print_verdict();
   end

   initial
   begin
      {sys_rst, negotiate, reverse_req, auto_feed_req, select_req} = 5'h10;
      {init_req, tx_valid, hold_busy, paper_jam, go_offline} = 5'h00;
      mode_sel = MODE_STANDARD;
      tx_data = 8'h00;
      ack_wait = 4'h2;
      repeat (6) @(posedge clk_sys);
      #10 sys_rst = 1'b0;
      step(2);
      test_reset();
      test_bytes();
      test_busy();
      test_controls();
      test_init();
      test_modes();
      test_status();
      print_verdict();
   end
endmodule
